// ### lgc_pkg.sv
// Constants for the link general-purpose pin control block
`default_nettype none
package lgc_pkg;
    localparam logic [7:0] LGC_OFS_PIN0  = 8'h0d;
    localparam logic [7:0] LGC_OFS_PIN12 = 8'h0e;
    localparam logic [7:0] LGC_OFS_PIN3  = 8'h0f;
    localparam logic [7:0] LGC_OFS_L56   = 8'h10;
    localparam logic [7:0] LGC_OFS_L78   = 8'h11;
    localparam logic [7:0] LGC_OFS_ST_LO = 8'h1c;
    localparam logic [7:0] LGC_OFS_ST_HI = 8'h1d;
    localparam int         LGC_NCFG      = 5;
    localparam int         LGC_NPIN      = 8;
    localparam int         LGC_NLINK     = 4;
    localparam logic [7:0] LGC_CFG_RST   = 8'h00;
    // Mode codes
    localparam logic [3:0] LGC_MODE_LOW  = 4'h1;
    localparam logic [3:0] LGC_MODE_HIGH = 4'h9;
    localparam logic [3:0] LGC_MODE_IN   = 4'h3;
    localparam logic [3:0] LGC_MODE_FWD  = 4'h3;
    localparam logic [3:0] LGC_MODE_BACK = 4'h5;
    // Pin to config register index and nibble (1 = upper)
    localparam int LGC_PIN_REG [8] = '{0, 1, 1, 2, 3, 3, 4, 4};
    localparam int LGC_PIN_HI  [8] = '{0, 0, 1, 0, 0, 1, 0, 1};
    // Status bit holes
    localparam int LGC_ST_LO_GAP = 4;
    // Far-end fast mode codes
    localparam logic [2:0] LGC_FAST_NORM = 3'b000;
    localparam logic [2:0] LGC_FAST_4    = 3'b011;
    localparam logic [2:0] LGC_FAST_2    = 3'b010;
    localparam logic [2:0] LGC_FAST_1    = 3'b001;
    // Back-channel line rates in Mbps
    localparam logic [4:0] LGC_RATE_LO  = 5'd5;
    localparam logic [4:0] LGC_RATE_MID = 5'd10;
    localparam logic [4:0] LGC_RATE_HI  = 5'd20;
    localparam int         LGC_BC_MARGIN_PCT = 20;
    localparam int         LGC_OVERSAMPLE    = 4;
    // Effective pin rate in kHz: [fast set][line rate]
    localparam logic [10:0] LGC_EFF_KHZ [4][3] = '{
        '{11'd33,  11'd66,   11'd133},
        '{11'd200, 11'd400,  11'd800},
        '{11'd333, 11'd666,  11'd1333},
        '{11'd500, 11'd1000, 11'd2000}};
endpackage : lgc_pkg
`default_nettype wire

// ### lgc_gpio.sv
// Link general-purpose pin control logic
`timescale 1ns/1ps
`default_nettype none
module lgc_gpio
    import lgc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Power-down pin, active low
    input  wire logic        power_down_n,
    // Local register access
    input  wire logic        loc_wr,
    input  wire logic        loc_rd,
    input  wire logic [7:0]  loc_addr,
    input  wire logic [7:0]  loc_wdata,
    output logic      [7:0]  loc_rdata,
    // Remote register access from the control channel
    input  wire logic        rem_wr,
    input  wire logic        rem_rd,
    input  wire logic [7:0]  rem_addr,
    input  wire logic [7:0]  rem_wdata,
    output logic      [7:0]  rem_rdata,
    // Pins: 0-3 link-carried, 4-7 register-only 5-8
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe,
    // Forward channel pin bits
    output logic      [3:0]  fwd_gpio,
    output logic      [3:0]  fwd_gpio_en,
    // Back channel frame samples
    input  wire logic        bc_valid,
    input  wire logic [3:0]  bc_gpio,
    input  wire logic [2:0]  fast_control_mode,
    input  wire logic        backlink_rate_select,
    input  wire logic        backlink_high_speed,
    // Shared audio inputs and link status
    output logic      [3:0]  audio_in,
    output logic      [4:0]  bc_rate_mbps,
    output logic      [10:0] bc_eff_khz
);
    logic [7:0]  cfg_r [LGC_NCFG];
    logic [7:0]  cfg_nxt [LGC_NCFG];
    logic [7:0]  pin_m1_r, pin_s_r;
    logic        pd_m1_r, pd_s_r;
    logic [3:0]  bc_hold_r, bc_hold_nxt;
    logic [3:0]  mode [LGC_NPIN];
    logic [7:0]  loc_rdata_nxt, rem_rdata_nxt;
    logic [7:0]  pin_out_nxt, pin_oe_nxt;
    logic [3:0]  fwd_nxt, fwd_en_nxt, audio_nxt;
    logic [4:0]  rate_nxt;
    logic [10:0] eff_nxt;

    function automatic logic [7:0] rd_mux(input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        if (a >= LGC_OFS_PIN0 && a <= LGC_OFS_L78)
            d = cfg_r[3'(a - LGC_OFS_PIN0)];
        else if (a == LGC_OFS_ST_LO) begin
            d = {pin_s_r[6:4], 1'b0, pin_s_r[3:0]};
            d[LGC_ST_LO_GAP] = 1'b0;
        end else if (a == LGC_OFS_ST_HI)
            d = {7'h00, pin_s_r[7]};
        return d;
    endfunction : rd_mux

    function automatic logic hit(input logic [7:0] a, input int i);
        return a == 8'(int'(LGC_OFS_PIN0) + i);
    endfunction : hit

    // Fast mode decides which back-channel pins carry samples
    function automatic logic [3:0] bc_mask(input logic [2:0] f);
        unique case (f)
            LGC_FAST_1: bc_mask = 4'h1;
            LGC_FAST_2: bc_mask = 4'h3;
            default:    bc_mask = 4'hf;
        endcase
    endfunction : bc_mask

    // Pin and power-down synchronisers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_m1_r <= 8'h00;
            pin_s_r  <= 8'h00;
            pd_m1_r  <= 1'b0;
            pd_s_r   <= 1'b0;
        end else begin
            pin_m1_r <= pin_in;
            pin_s_r  <= pin_m1_r;
            pd_m1_r  <= power_down_n;
            pd_s_r   <= pd_m1_r;
        end
    end

    // Registers; local wins a same-cycle clash with remote
    always_comb begin
        for (int i = 0; i < LGC_NCFG; i++) begin
            cfg_nxt[i] = cfg_r[i];
            if (rem_wr && hit(rem_addr, i))
                cfg_nxt[i] = rem_wdata;
            if (loc_wr && hit(loc_addr, i))
                cfg_nxt[i] = loc_wdata;
            if (!pd_s_r)
                cfg_nxt[i] = LGC_CFG_RST;
        end
        loc_rdata_nxt = loc_rd ? rd_mux(loc_addr) : loc_rdata;
        rem_rdata_nxt = rem_rd ? rd_mux(rem_addr) : rem_rdata;
    end

    // Mode nibble per pin
    always_comb begin
        for (int p = 0; p < LGC_NPIN; p++)
            mode[p] = LGC_PIN_HI[p] != 0 ? cfg_r[LGC_PIN_REG[p]][7:4]
                                         : cfg_r[LGC_PIN_REG[p]][3:0];
    end

    // Pin drive, link transport and audio sharing
    always_comb begin
        bc_hold_nxt = bc_hold_r;
        if (bc_valid)
            bc_hold_nxt = (bc_gpio & bc_mask(fast_control_mode))
                        | (bc_hold_r & ~bc_mask(fast_control_mode));
        if (!pd_s_r)
            bc_hold_nxt = 4'h0;
        pin_out_nxt = 8'h00;
        pin_oe_nxt  = 8'h00;
        fwd_nxt     = 4'h0;
        fwd_en_nxt  = 4'h0;
        for (int p = 0; p < LGC_NPIN; p++) begin
            if (mode[p] == LGC_MODE_LOW) begin
                pin_oe_nxt[p] = 1'b1;
            end else if (mode[p] == LGC_MODE_HIGH) begin
                pin_oe_nxt[p]  = 1'b1;
                pin_out_nxt[p] = 1'b1;
            end
        end
        // Only the four link pins reach the forward channel
        for (int p = 0; p < LGC_NLINK; p++) begin
            if (mode[p] == LGC_MODE_FWD) begin
                fwd_nxt[p]    = pin_s_r[p];
                fwd_en_nxt[p] = 1'b1;
            end else if (mode[p] == LGC_MODE_BACK) begin
                pin_oe_nxt[p]  = 1'b1;
                pin_out_nxt[p] = bc_hold_r[p];
            end
        end
        // Audio sees nothing while the pin is in register mode
        for (int a = 0; a < 4; a++) begin
            logic [3:0] m;
            m = mode[LGC_NLINK + a];
            audio_nxt[a] = (m == LGC_MODE_LOW || m == LGC_MODE_HIGH ||
                            m == LGC_MODE_IN) ? 1'b0
                                              : pin_s_r[LGC_NLINK + a];
        end
    end

    // Line rate chosen by far end, for status only
    always_comb begin
        int fi, ri;
        fi = 0;
        ri = 0;
        if (backlink_high_speed) begin
            rate_nxt = LGC_RATE_HI;
            ri = 2;
        end else if (backlink_rate_select) begin
            rate_nxt = LGC_RATE_MID;
            ri = 1;
        end else
            rate_nxt = LGC_RATE_LO;
        unique case (fast_control_mode)
            LGC_FAST_4: fi = 1;
            LGC_FAST_2: fi = 2;
            LGC_FAST_1: fi = 3;
            default:    fi = 0;
        endcase
        eff_nxt = LGC_EFF_KHZ[fi][ri];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < LGC_NCFG; i++)
                cfg_r[i] <= LGC_CFG_RST;
            loc_rdata    <= 8'h00;
            rem_rdata    <= 8'h00;
            bc_hold_r    <= 4'h0;
            pin_out      <= 8'h00;
            pin_oe       <= 8'h00;
            fwd_gpio     <= 4'h0;
            fwd_gpio_en  <= 4'h0;
            audio_in     <= 4'h0;
            bc_rate_mbps <= LGC_RATE_LO;
            bc_eff_khz   <= LGC_EFF_KHZ[0][0];
        end else begin
            cfg_r        <= cfg_nxt;
            loc_rdata    <= loc_rdata_nxt;
            rem_rdata    <= rem_rdata_nxt;
            bc_hold_r    <= bc_hold_nxt;
            pin_out      <= pin_out_nxt;
            pin_oe       <= pin_oe_nxt;
            fwd_gpio     <= fwd_nxt;
            fwd_gpio_en  <= fwd_en_nxt;
            audio_in     <= audio_nxt;
            bc_rate_mbps <= rate_nxt;
            bc_eff_khz   <= eff_nxt;
        end
    end

    // Checks
    a_fwd_carry: assert property (@(posedge clk) disable iff (!rst_n)
        mode[0] == LGC_MODE_FWD |=> fwd_gpio_en[0] &&
        fwd_gpio[0] == $past(pin_s_r[0]))
        else $error("forward pin 0 not carried");
    a_back_drive: assert property (@(posedge clk) disable iff (!rst_n)
        mode[3] == LGC_MODE_BACK |=> pin_oe[3] &&
        pin_out[3] == $past(bc_hold_r[3]))
        else $error("back-channel pin 3 not driven");
    a_pin_map: assert property (@(posedge clk) disable iff (!rst_n)
        loc_wr && loc_addr == LGC_OFS_PIN12 &&
        loc_wdata[7:4] == LGC_MODE_HIGH && pd_s_r
        |=> ##1 pin_oe[2] && pin_out[2])
        else $error("pin 2 nibble misplaced");
    a_drive_low: assert property (@(posedge clk) disable iff (!rst_n)
        mode[5] == LGC_MODE_LOW |=> pin_oe[5] && !pin_out[5])
        else $error("drive low failed");
    a_local_map: assert property (@(posedge clk) disable iff (!rst_n)
        loc_wr && loc_addr == LGC_OFS_L78 && pd_s_r
        |=> mode[7] == $past(loc_wdata[7:4]))
        else $error("pin 8 nibble misplaced");
    a_status_hi: assert property (@(posedge clk) disable iff (!rst_n)
        loc_rd && loc_addr == LGC_OFS_ST_HI
        |=> loc_rdata == {7'h00, $past(pin_s_r[7])})
        else $error("pin 8 status wrong");
    a_audio_block: assert property (@(posedge clk) disable iff (!rst_n)
        mode[4] == LGC_MODE_IN |=> !audio_in[0])
        else $error("audio not overridden");
    a_remote_wr: assert property (@(posedge clk) disable iff (!rst_n)
        rem_wr && !loc_wr && rem_addr == LGC_OFS_L56 && pd_s_r
        |=> cfg_r[3] == $past(rem_wdata))
        else $error("remote write lost");
    a_fast_mask: assert property (@(posedge clk) disable iff (!rst_n)
        bc_valid && fast_control_mode == LGC_FAST_1 && pd_s_r
        |=> bc_hold_r[3:1] == $past(bc_hold_r[3:1]) &&
        bc_hold_r[0] == $past(bc_gpio[0]))
        else $error("fast mode mask wrong");
    a_rate_sel: assert property (@(posedge clk) disable iff (!rst_n)
        backlink_high_speed |=> bc_rate_mbps == LGC_RATE_HI)
        else $error("rate select wrong");
    a_pd_clear: assert property (@(posedge clk) disable iff (!rst_n)
        !pd_s_r |=> cfg_r[0] == LGC_CFG_RST && cfg_r[4] == LGC_CFG_RST)
        else $error("power-down did not clear");
    c_fwd: cover property (@(posedge clk) fwd_gpio_en[0] && fwd_gpio[0]);
    c_back: cover property (@(posedge clk) bc_valid ##1 pin_oe[3]);
    c_pd: cover property (@(posedge clk) pd_s_r ##1 !pd_s_r);
endmodule : lgc_gpio
`default_nettype wire

// ### lgc_far_end.sv
// Far-end deserializer model driving the back channel
`timescale 1ns/1ps
`default_nettype none
module lgc_far_end (
    // Clock, reset and bench commands
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       send,
    input  wire logic [3:0] sample,
    input  wire logic [2:0] fast,
    input  wire logic       rsel,
    input  wire logic       hs,
    // Back channel toward the block
    output logic            bc_valid,
    output logic      [3:0] bc_gpio,
    output logic      [2:0] fast_control_mode,
    output logic            backlink_rate_select,
    output logic            backlink_high_speed
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bc_valid <= 1'b0;
            bc_gpio <= 4'h0;
            fast_control_mode <= 3'b000;
            backlink_rate_select <= 1'b0;
            backlink_high_speed <= 1'b0;
        end else begin
            bc_valid <= send;
            // Bits toggle between frames so stale data never looks valid
            bc_gpio <= send ? sample : ~bc_gpio;
            fast_control_mode <= fast;
            backlink_rate_select <= rsel;
            backlink_high_speed <= hs;
        end
    end
endmodule : lgc_far_end
`default_nettype wire

// ### lgc_tb.sv
// Self-checking bench for the link pin control block
`timescale 1ns/1ps
`default_nettype none
`define CMP(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("unexpected %0t got %h exp %h", $time, got, exp); \
    end \
end
module testbench;
    import lgc_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, power_down_n = 1'b1;
    logic        loc_wr = 1'b0, loc_rd = 1'b0, rem_wr = 1'b0, rem_rd = 1'b0;
    logic [7:0]  loc_addr = 8'h00, loc_wdata = 8'h00, ext = 8'h00;
    logic [7:0]  rem_addr = 8'h00, rem_wdata = 8'h00;
    logic [7:0]  loc_rdata, rem_rdata, pin_out, pin_oe;
    logic [3:0]  fwd_gpio, fwd_gpio_en, bc_gpio, audio_in, sample = 4'h0;
    logic [2:0]  fast_control_mode, fast = 3'b000;
    logic        bc_valid, backlink_rate_select, backlink_high_speed;
    logic        send = 1'b0, rsel = 1'b0, hs = 1'b0, chk = 1'b0;
    logic [4:0]  bc_rate_mbps;
    logic [10:0] bc_eff_khz;
    logic [18:0] q[$];
    logic [18:0] n;
    logic [31:0] seed = 32'h8ec6, r;
    int          fails = 0, cmp_count = 0, i, j, k;
    logic [2:0]  fc [4] = '{3'b000, 3'b011, 3'b010, 3'b001};
    logic [3:0]  msk [4] = '{4'hf, 4'hf, 4'h3, 4'h1};
    logic [4:0]  rate [4] = '{5'd5, 5'd10, 5'd20, 5'd20};
    logic [10:0] eff [4][3] = '{'{11'd33, 11'd66, 11'd133},
        '{11'd200, 11'd400, 11'd800}, '{11'd333, 11'd666, 11'd1333},
        '{11'd500, 11'd1000, 11'd2000}};
    logic [7:0]  ra [7] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h1c, 8'h1d};
    // Pin wire level: our drive wins while the block leaves the pin free
    wire logic [7:0] pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
    always #5 clk = ~clk;
    lgc_gpio u_lgc_gpio (
        .clk, .rst_n, .power_down_n, .loc_wr, .loc_rd, .loc_addr, .loc_wdata,
        .loc_rdata, .rem_wr, .rem_rd, .rem_addr, .rem_wdata, .rem_rdata,
        .pin_in, .pin_out, .pin_oe, .fwd_gpio, .fwd_gpio_en, .bc_valid,
        .bc_gpio, .fast_control_mode, .backlink_rate_select,
        .backlink_high_speed, .audio_in, .bc_rate_mbps, .bc_eff_khz);
    lgc_far_end u_lgc_far_end (
        .clk, .rst_n, .send, .sample, .fast, .rsel, .hs, .bc_valid, .bc_gpio,
        .fast_control_mode, .backlink_rate_select, .backlink_high_speed);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [15:0] view(input logic [2:0] s);
        case (s)
            3'h0: return {8'h00, loc_rdata};
            3'h1: return {8'h00, rem_rdata};
            3'h2: return {8'h00, pin_out};
            3'h3: return {8'h00, pin_oe};
            3'h4: return {8'h00, fwd_gpio_en, fwd_gpio};
            3'h5: return {12'h000, audio_in};
            3'h6: return {11'h000, bc_rate_mbps};
            default: return {5'h00, bc_eff_khz};
        endcase
    endfunction : view
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    // Strobe held across the taking edge, then one idle cycle
    task automatic acc(input logic m, w, input logic [7:0] a, d);
        if (m) {rem_wr, rem_rd, rem_addr, rem_wdata} = {w, !w, a, d};
        else {loc_wr, loc_rd, loc_addr, loc_wdata} = {w, !w, a, d};
        tick();
        {loc_wr, loc_rd, rem_wr, rem_rd} = 4'h0;
        tick();
    endtask : acc
    task automatic note(input logic [2:0] s, input logic [15:0] v);
        q.push_back({s, v});
        chk = 1'b1;
        tick();
        chk = 1'b0;
        tick();
    endtask : note
    task automatic rd(input logic m, input logic [7:0] a, logic [15:0] v);
        acc(m, 1'b0, a, 8'h00);
        note({2'b00, m}, v);
    endtask : rd
    // One nibble per pin, pin 0 lowest; pins 4 and 5 through remote port
    task automatic modes(input logic [31:0] m);
        acc(1'b0, 1'b1, 8'h0d, {4'h0, m[3:0]});
        acc(1'b0, 1'b1, 8'h0e, m[11:4]);
        acc(1'b0, 1'b1, 8'h0f, {4'h0, m[15:12]});
        acc(1'b1, 1'b1, 8'h10, m[23:16]);
        acc(1'b0, 1'b1, 8'h11, m[31:24]);
    endtask : modes
    task automatic frame(input logic [3:0] d, input logic [2:0] f);
        {fast, sample, send} = {f, d, 1'b1};
        tick();
        send = 1'b0;
        repeat (3) tick();
    endtask : frame
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    // Falling edge, so outputs are settled when looked at
    always @(negedge clk) begin
        if (chk === 1'b1) begin
            n = q.pop_front();
            `CMP(view(n[18:16]), n[15:0])
        end
    end
    initial begin
        repeat (20) tick();
        rst_n = 1'b1;
        repeat (4) tick();
        for (i = 0; i < 7; i++)
            rd(i[0], ra[i], 16'h0000);
        note(6, 16'd5);
        note(7, 16'd33);
        $display("test defaults done");
        for (i = 0; i < 8; i++) begin
            modes(32'h11111111 | (32'h8 << (4 * i)));
            note(2, 16'h1 << i);
            note(3, 16'h00ff);
        end
        rd(1'b1, 8'h11, 16'h0091);
        rd(1'b0, 8'h1d, 16'h0001);
        $display("test drive map done");
        modes(32'h33333333);
        for (i = 0; i < 4; i++) begin
            r = xs();
            ext = r[7:0];
            repeat (3) tick();
            rd(i[0], 8'h1c, {8'h00, r[6:4], 1'b0, r[3:0]});
            rd(!i[0], 8'h1d, {15'h0, r[7]});
            note(4, {8'h00, 4'hf, r[3:0]});
            note(5, 16'h0000);
        end
        modes(32'h0);
        note(5, {12'h0, r[7:4]});
        note(4, 16'h0000);
        acc(1'b0, 1'b1, 8'h1c, 8'hff);
        acc(1'b1, 1'b1, 8'h20, 8'hff);
        rd(1'b0, 8'h1c, {8'h00, r[6:4], 1'b0, r[3:0]});
        rd(1'b1, 8'h20, 16'h0000);
        $display("test inputs done");
        modes(32'h00005555);
        for (k = 0; k < 4; k++) begin
            r = xs();
            frame(4'h0, 3'b000);
            frame(r[3:0], fc[k]);
            note(2, {12'h0, r[3:0] & msk[k]});
            note(3, 16'h000f);
        end
        for (j = 0; j < 4; j++) begin
            for (k = 0; k < 4; k++) begin
                {hs, rsel, fast} = {j[1:0], fc[k]};
                repeat (4) tick();
                note(6, {11'h0, rate[j]});
                note(7, {5'h0, eff[k][j > 2 ? 2 : j]});
            end
        end
        $display("test back channel done");
        modes(32'h99999999);
        power_down_n = 1'b0;
        repeat (4) tick();
        acc(1'b0, 1'b1, 8'h0d, 8'h09);
        power_down_n = 1'b1;
        repeat (3) tick();
        rd(1'b1, 8'h0d, 16'h0000);
        note(3, 16'h0000);
        $display("test power down done");
        tally_and_finish();
    end
    // The run needs about 480 cycles; forty times that means a hang
    initial begin
        #200000;
        fails++;
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
